// [spcr_host_model.sv]
`timescale 1ns/1ps
// Host controller on the register port; it drives off the falling edge
module spcr_host_model
  import spcr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic wr_en,
  output logic rd_en,
  output logic [12:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  // Idle port at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 13'h0000;
    wdata = 8'h00;
  end

  // One byte written, held across the taking edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    wdata = ~d; // Released data must not look valid
  endtask

  // One byte read; answer taken at the next falling edge, half a cycle after the taking edge
  task automatic rd(input logic [12:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    d = rdata;
    v = rd_valid;
  endtask
endmodule

// [spcr_mirror_reg.sv]
`timescale 1ns/1ps
// Buffered register: writes land in the buffer, an update moves them on
module spcr_mirror_reg
  import spcr_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wr_en,
  input wire logic [W-1:0] wdata,
  // Transfer event
  input wire logic update,
  // Buffer and active copies
  output logic [W-1:0] buf_q,
  output logic [W-1:0] act_q
);

  // Buffer takes each write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      buf_q <= RST_VAL;
    else if (wr_en)
      buf_q <= wdata;
  end

  // Active copy changes only on an update; a write in the same cycle
  // is seen by the next update, not this one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      act_q <= RST_VAL;
    else if (update)
      act_q <= buf_q;
  end

endmodule

// [spcr_out_div.sv]
`timescale 1ns/1ps
// Divide-by-two prescaler followed by the integer output divider
module spcr_out_div
  import spcr_pkg::*;
#(
  parameter int DIV_RATIO = 1,
  parameter int CNT_W = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reset controls from the divider reset register
  input wire logic presc_rst,
  input wire logic div_rst,
  // Divided output tick
  output logic tick_q
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV_RATIO - 1);

  logic presc_q;
  logic [CNT_W-1:0] cnt_q;

  // Prescaler reset acts at once, without waiting for a clock edge
  wire presc_arst = rst | presc_rst;

  // Prescaler output is an enable high every second cycle
  always_ff @(posedge clk or posedge presc_arst)
  begin
    if (presc_arst)
      presc_q <= 1'b0;
    else
      presc_q <= ~presc_q;
  end

  // Integer divider; its reset is taken only on a prescaler tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (presc_q)
      cnt_q <= (div_rst || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
  end

  // Output tick at the end of each divided period
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_q <= 1'b0;
    else
      tick_q <= presc_q & ~div_rst & (cnt_q == LAST);
  end

endmodule

// [spcr_pkg.sv]
// Shared constants of the power, reset and system clock PLL control bank
package spcr_pkg;

  // ****************************************************************
  // Register addresses on the serial control port
  // ****************************************************************
  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_READBACK_SRC = 13'h0004;
  localparam logic [12:0] ADDR_SW_UPDATE = 13'h0005;
  localparam logic [12:0] ADDR_POWER_DOWN = 13'h0010;
  localparam logic [12:0] ADDR_RSVD_POWER = 13'h0011;
  localparam logic [12:0] ADDR_CORE_RESET = 13'h0012;
  localparam logic [12:0] ADDR_DIV_RESET = 13'h0013;
  localparam logic [12:0] ADDR_FB_DIVIDER = 13'h0020;
  localparam logic [12:0] ADDR_RSVD_DIVIDER = 13'h0021;
  localparam logic [12:0] ADDR_PLL_PARAMS = 13'h0022;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] PD_RESET_NORMAL = 8'hc0;
  localparam logic [7:0] PD_RESET_STRAP = 8'hd0;
  localparam logic [7:0] READBACK_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET_RESET = 8'h00;
  localparam logic [7:0] FB_DIV_RESET = 8'h00;
  localparam logic [7:0] PLL_PARAMS_RESET = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_READBACK_BUF = 0;
  localparam int BIT_SW_UPDATE = 0;
  localparam int BIT_HSTL_PD = 7;
  localparam int BIT_CMOS_EN = 6;
  localparam int BIT_DOUBLER_EN = 5;
  localparam int BIT_MULT_PD = 4;
  localparam int BIT_CHIP_OFF = 1;
  localparam int BIT_DIG_GATE = 0;
  localparam int BIT_CORE_RESET = 0;
  localparam int BIT_FUND_OFF = 7;
  localparam int BIT_PRESC_RESET = 3;
  localparam int BIT_INTDIV_RESET = 1;
  localparam int FB_FIELD_W = 5;
  localparam int BIT_AUTO_RANGE = 7;
  localparam int BIT_REF_DOUBLER = 3;
  localparam int BIT_OSC_RANGE = 2;
  localparam int CP_LSB = 0;
  localparam int CP_W = 2;

  // Writable bits of the partly reserved registers
  localparam logic [7:0] DIV_RESET_MASK = 8'h8a;
  localparam logic [7:0] FB_DIV_MASK = 8'h1f;
  localparam logic [7:0] PLL_PARAMS_MASK = 8'h8f;

  // ****************************************************************
  // Feedback divider: fixed divide by two after an offset of two
  // ****************************************************************
  localparam int FB_RATIO_W = 7;
  localparam logic [6:0] FB_OFFSET = 7'h02;

  // ****************************************************************
  // Oscillator ranges in MHz
  // ****************************************************************
  localparam int OSC_LOW_BASE_MHZ = 700;
  localparam int OSC_LOW_TOP_MHZ = 810;
  localparam int OSC_HIGH_BASE_MHZ = 900;

  // ****************************************************************
  // Charge pump current codes and values in microamps
  // ****************************************************************
  typedef enum logic [1:0] {
    SPCR_CP_250 = 2'b00,
    SPCR_CP_375 = 2'b01,
    SPCR_CP_OFF = 2'b10,
    SPCR_CP_125 = 2'b11
  } spcr_cp_e;
  localparam int CP_UA_W = 9;
  localparam logic [8:0] CP_UA_250 = 9'h0fa;
  localparam logic [8:0] CP_UA_375 = 9'h177;
  localparam logic [8:0] CP_UA_125 = 9'h07d;
  localparam logic [8:0] CP_UA_OFF = 9'h000;

endpackage

// [spcr_regs.sv]
`timescale 1ns/1ps
// What this block does
// - Readback bit picks pending or active value
// - Writing update bit equals update pin; self-clears
// - Power-down reset value follows fourth strap
// - Bit 7 powers down the HSTL driver
// - Bit 6 switches the CMOS driver on
// - Bit 5 plus doubler enable runs doubler
// - Bit 4 powers down the clock multiplier
// - Bit 1 acts as power-down pin
// - Bit 0 gates digital clock, serial kept
// - Writing core reset bit pulses, then clears
// - Second reset register bits never self-clear
// - Bit 7 silences fundamental, spur outputs run
// - Bit 3 holds prescaler in async reset
// - Bit 1 resets divider on prescaler tick
// - Feedback ratio is two times field plus four
// - Auto ranging lets hardware choose range bit
// - Bit 3 adds reference doubler before PLL
// - Range bit: low from 700, high 900
// - Charge pump code decodes to current
// - Buffered writes wait for an update event
module spcr_regs
  import spcr_pkg::*;
#(
  parameter int REF_MHZ = 25,
  parameter int OUT_DIV_RATIO = 1
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register access from the serial control port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Device pins and neighbouring register bits
  input wire logic io_update_pin,
  input wire logic power_down_pin,
  input wire logic startup_strap_four,
  input wire logic hstl_doubler_en,
  // Power and enable controls
  output logic hstl_driver_off,
  output logic cmos_driver_on,
  output logic output_doubler_on,
  output logic multiplier_powerdown,
  output logic whole_chip_powerdown,
  output logic system_clock_run,
  output logic digital_clock_gate,
  // Resets and synthesis controls
  output logic synth_core_reset,
  output logic fundamental_output_off,
  output logic cmos_div_tick,
  // System clock PLL controls
  output logic [6:0] fb_div_ratio,
  output logic osc_range_select,
  output logic ref_doubler_on,
  output logic [8:0] cp_current_ua,
  output logic cp_off
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire hit_readback = reg_addr == ADDR_READBACK_SRC;
  wire hit_update = reg_addr == ADDR_SW_UPDATE;
  wire hit_power = reg_addr == ADDR_POWER_DOWN;
  wire hit_core_rst = reg_addr == ADDR_CORE_RESET;
  wire hit_div_rst = reg_addr == ADDR_DIV_RESET;
  wire hit_fb = reg_addr == ADDR_FB_DIVIDER;
  wire hit_pll = reg_addr == ADDR_PLL_PARAMS;

  // Write strobes; reserved and unmapped addresses get none
  wire wr_readback = reg_wr_en & hit_readback;
  wire wr_update = reg_wr_en & hit_update;
  wire wr_power = reg_wr_en & hit_power;
  wire wr_core_rst = reg_wr_en & hit_core_rst;
  wire wr_div_rst = reg_wr_en & hit_div_rst;
  wire wr_fb = reg_wr_en & hit_fb;
  wire wr_pll = reg_wr_en & hit_pll;

  // ****************************************************************
  // Update event: pin edge or software strobe
  // ****************************************************************
  logic rb_sel_q;
  logic sw_upd_q;
  logic upd_pin_q;

  wire pin_rise = io_update_pin & ~upd_pin_q;
  wire upd_evt = sw_upd_q | pin_rise;

  // Readback source select
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rb_sel_q <= READBACK_RESET[BIT_READBACK_BUF];
    else if (wr_readback)
      rb_sel_q <= reg_wdata[BIT_READBACK_BUF];
  end

  // Strobe lasts one cycle, so the bit clears itself
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sw_upd_q <= 1'b0;
      upd_pin_q <= 1'b0;
    end
    else
    begin
      sw_upd_q <= wr_update & reg_wdata[BIT_SW_UPDATE];
      upd_pin_q <= io_update_pin;
    end
  end

  // ****************************************************************
  // Power-down register with strap-dependent default
  // ****************************************************************
  logic [7:0] pd_q;
  logic strap_done_q;

  // The strap is caught on the first edge after reset release, so
  // the reset itself only ever loads a constant
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pd_q <= PD_RESET_NORMAL;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      pd_q <= startup_strap_four ? PD_RESET_STRAP : PD_RESET_NORMAL;
      strap_done_q <= 1'b1;
    end
    else if (wr_power)
      pd_q <= reg_wdata;
  end

  // ****************************************************************
  // Reset registers
  // ****************************************************************
  logic core_rst_q;
  logic [7:0] div_ctl_q;

  // Core reset pulses for one cycle per write of a one
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      core_rst_q <= 1'b0;
    else
      core_rst_q <= wr_core_rst & reg_wdata[BIT_CORE_RESET];
  end

  // Divider resets hold until software changes them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      div_ctl_q <= DIV_RESET_RESET;
    else if (wr_div_rst)
      div_ctl_q <= reg_wdata & DIV_RESET_MASK;
  end

  // ****************************************************************
  // Buffered PLL registers
  // ****************************************************************
  logic [7:0] fb_buf;
  logic [7:0] fb_act;
  logic [7:0] pll_buf;
  logic [7:0] pll_act;

  spcr_mirror_reg #(
    .W(8),
    .RST_VAL(FB_DIV_RESET)
  ) u_fb_mirror (
    .clk(core_clk),
    .rst(rst),
    .wr_en(wr_fb),
    .wdata(reg_wdata & FB_DIV_MASK),
    .update(upd_evt),
    .buf_q(fb_buf),
    .act_q(fb_act)
  );

  spcr_mirror_reg #(
    .W(8),
    .RST_VAL(PLL_PARAMS_RESET)
  ) u_pll_mirror (
    .clk(core_clk),
    .rst(rst),
    .wr_en(wr_pll),
    .wdata(reg_wdata & PLL_PARAMS_MASK),
    .update(upd_evt),
    .buf_q(pll_buf),
    .act_q(pll_act)
  );

  // ****************************************************************
  // PLL derived values
  // ****************************************************************
  // Ratio from a field value: fixed divide by two after offset two
  function automatic logic [6:0] fb_ratio(input logic [7:0] fld);
    fb_ratio = (7'(fld[FB_FIELD_W-1:0]) + FB_OFFSET) << 1;
  endfunction

  wire [6:0] ratio_act = fb_ratio(fb_act);
  wire [6:0] ratio_buf = fb_ratio(fb_buf);
  wire ref_x2 = pll_act[BIT_REF_DOUBLER];

  // Expected oscillator frequency; anything above the top of the low
  // range goes high, which also covers the gap between the ranges
  wire [15:0] ref_eff_mhz = ref_x2 ? 16'(2 * REF_MHZ) : 16'(REF_MHZ);
  wire [15:0] vco_mhz = 16'(ref_eff_mhz * {9'h000, ratio_act});
  wire auto_high = vco_mhz > 16'(OSC_LOW_TOP_MHZ);
  wire auto_on = pll_act[BIT_AUTO_RANGE];
  wire range_eff = auto_on ? auto_high : pll_act[BIT_OSC_RANGE];

  // Active copy as seen by the rest of the chip and by readback
  wire [7:0] pll_eff = {pll_act[7:3], range_eff, pll_act[1:0]};

  // Charge pump decode
  wire [1:0] cp_code = pll_act[CP_LSB +: CP_W];
  wire [8:0] cp_ua_d = (cp_code == SPCR_CP_250) ? CP_UA_250 :
                       (cp_code == SPCR_CP_375) ? CP_UA_375 :
                       (cp_code == SPCR_CP_125) ? CP_UA_125 :
                       CP_UA_OFF;
  wire cp_off_d = cp_code == SPCR_CP_OFF;

  // ****************************************************************
  // Power controls
  // ****************************************************************
  // Full power-down overrides every other enable but the serial port
  wire chip_off = pd_q[BIT_CHIP_OFF] | power_down_pin;
  wire hstl_off_d = pd_q[BIT_HSTL_PD] | chip_off;
  wire cmos_on_d = pd_q[BIT_CMOS_EN] & ~chip_off;
  wire dbl_on_d = pd_q[BIT_DOUBLER_EN] & hstl_doubler_en & ~chip_off;
  wire mult_pd_d = pd_q[BIT_MULT_PD] | chip_off;
  wire dig_gate_d = pd_q[BIT_DIG_GATE] | chip_off;

  // Output flops for power and reset controls
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hstl_driver_off <= PD_RESET_NORMAL[BIT_HSTL_PD];
      cmos_driver_on <= PD_RESET_NORMAL[BIT_CMOS_EN];
      output_doubler_on <= 1'b0;
      multiplier_powerdown <= PD_RESET_NORMAL[BIT_MULT_PD];
      whole_chip_powerdown <= 1'b0;
      system_clock_run <= 1'b1;
      digital_clock_gate <= 1'b0;
      fundamental_output_off <= 1'b0;
    end
    else
    begin
      hstl_driver_off <= hstl_off_d;
      cmos_driver_on <= cmos_on_d;
      output_doubler_on <= dbl_on_d;
      multiplier_powerdown <= mult_pd_d;
      whole_chip_powerdown <= chip_off;
      system_clock_run <= ~chip_off;
      digital_clock_gate <= dig_gate_d;
      fundamental_output_off <= div_ctl_q[BIT_FUND_OFF];
    end
  end

  // Core reset goes straight out of its own flop
  assign synth_core_reset = core_rst_q;

  // Output flops for PLL controls
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fb_div_ratio <= fb_ratio(FB_DIV_RESET);
      osc_range_select <= 1'b0;
      ref_doubler_on <= 1'b0;
      cp_current_ua <= CP_UA_250;
      cp_off <= 1'b0;
    end
    else
    begin
      fb_div_ratio <= ratio_act;
      osc_range_select <= range_eff;
      ref_doubler_on <= ref_x2;
      cp_current_ua <= cp_ua_d;
      cp_off <= cp_off_d;
    end
  end

  // ****************************************************************
  // Output divider
  // ****************************************************************
  spcr_out_div #(
    .DIV_RATIO(OUT_DIV_RATIO),
    .CNT_W(16)
  ) u_out_div (
    .clk(core_clk),
    .rst(rst),
    .presc_rst(div_ctl_q[BIT_PRESC_RESET]),
    .div_rst(div_ctl_q[BIT_INTDIV_RESET]),
    .tick_q(cmos_div_tick)
  );

  // ****************************************************************
  // Readback
  // ****************************************************************
  // Buffered registers show pending or active copy as selected
  wire [7:0] fb_rd = rb_sel_q ? fb_buf : fb_act;
  wire [7:0] pll_rd = rb_sel_q ? pll_buf : pll_eff;
  wire [7:0] rd_mux =
    hit_readback ? {7'h00, rb_sel_q} :
    hit_update ? {7'h00, sw_upd_q} :
    hit_power ? pd_q :
    hit_core_rst ? {7'h00, core_rst_q} :
    hit_div_rst ? div_ctl_q :
    hit_fb ? fb_rd :
    hit_pll ? pll_rd :
    8'h00;

  // Read data is registered, valid one cycle after the request
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd_en ? rd_mux : reg_rdata;
      reg_rd_valid <= reg_rd_en;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_sw_update;
    wr_update && reg_wdata[BIT_SW_UPDATE];
  endsequence

  sequence s_core_rst_once;
    (wr_core_rst && reg_wdata[BIT_CORE_RESET]) ##1 !wr_core_rst;
  endsequence

  a_readback_source: assert property (@(posedge core_clk)
    disable iff (rst) reg_rd_en && hit_fb |=>
      reg_rdata == ($past(rb_sel_q) ? $past(fb_buf) : $past(fb_act)))
    else $error("feedback readback source wrong");
  a_sw_update_fires: assert property (@(posedge core_clk)
    disable iff (rst) s_sw_update |=>
      upd_evt ##2 (fb_div_ratio == $past(ratio_buf, 2)))
    else $error("software update did not move buffer");
  a_strap_default: assert property (@(posedge core_clk)
    disable iff (rst) $rose(strap_done_q) |->
      pd_q == ($past(startup_strap_four) ? PD_RESET_STRAP : PD_RESET_NORMAL))
    else $error("power-down default ignores strap");
  a_chip_off_stop: assert property (@(posedge core_clk)
    disable iff (rst) chip_off |=> !system_clock_run && multiplier_powerdown
      && hstl_driver_off && !cmos_driver_on && digital_clock_gate)
    else $error("full power-down left something running");
  a_doubler_gate: assert property (@(posedge core_clk)
    disable iff (rst) output_doubler_on |->
      $past(hstl_doubler_en) && $past(pd_q[BIT_DOUBLER_EN]))
    else $error("doubler on without both enables");
  a_core_rst_pulse: assert property (@(posedge core_clk)
    disable iff (rst) s_core_rst_once |->
      synth_core_reset ##1 !synth_core_reset)
    else $error("core reset did not clear itself");
  a_div_rst_hold: assert property (@(posedge core_clk)
    disable iff (rst) !wr_div_rst |=> $stable(div_ctl_q))
    else $error("divider reset register changed alone");
  a_no_early_use: assert property (@(posedge core_clk)
    disable iff (rst) !upd_evt |=> $stable(fb_act) && $stable(pll_act))
    else $error("buffered value took effect without update");
  a_auto_range: assert property (@(posedge core_clk)
    disable iff (rst) auto_on |=> osc_range_select == $past(auto_high))
    else $error("auto ranging did not set range");
  a_cp_off: assert property (@(posedge core_clk)
    disable iff (rst) cp_code == SPCR_CP_OFF |=>
      cp_off && cp_current_ua == CP_UA_OFF)
    else $error("charge pump off code misdecoded");
  a_presc_hold: assert property (@(posedge core_clk)
    disable iff (rst) div_ctl_q[BIT_PRESC_RESET] [*2] |=> !cmos_div_tick)
    else $error("divider ticked with prescaler in reset");
  a_reserved_zero: assert property (@(posedge core_clk)
    disable iff (rst) reg_rd_en && (reg_addr == ADDR_RSVD_POWER ||
      reg_addr == ADDR_RSVD_DIVIDER) |=> reg_rdata == 8'h00)
    else $error("reserved address read nonzero");

endmodule

// [spcr_regs_test.sv]
`timescale 1ns/1ps
// Self-checking bench of the control register bank
module spcr_regs_test
  import spcr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en, rd_en, rd_valid, upd_pin = 1'b0, pd_pin = 1'b0;
  logic strap = 1'b0, dbl_en = 1'b1;
  logic [12:0] addr;
  logic [7:0] wdata, rdata;
  logic hstl_off, cmos_on, dbl_on, mult_pd, chip_off, sys_run, dig_gate;
  logic core_rst, fund_off, tick, osc_rng, ref_dbl, cp_off;
  logic [6:0] fb_ratio;
  logic [8:0] cp_ua;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int ticks = 0;
  int pulses = 0;

  // ******
  // Clock, timeout and event counters
  // ******
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    ticks += tick;
    pulses += core_rst;
    if (cycles == 5000)
    begin
      failures++; // Hang: count it and close
      end_sim();
    end
  end

  spcr_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rd_valid(rd_valid), .io_update_pin(upd_pin),
    .power_down_pin(pd_pin), .startup_strap_four(strap),
    .hstl_doubler_en(dbl_en), .hstl_driver_off(hstl_off),
    .cmos_driver_on(cmos_on), .output_doubler_on(dbl_on),
    .multiplier_powerdown(mult_pd), .whole_chip_powerdown(chip_off),
    .system_clock_run(sys_run), .digital_clock_gate(dig_gate),
    .synth_core_reset(core_rst), .fundamental_output_off(fund_off),
    .cmos_div_tick(tick), .fb_div_ratio(fb_ratio),
    .osc_range_select(osc_rng), .ref_doubler_on(ref_dbl),
    .cp_current_ua(cp_ua), .cp_off(cp_off));

  spcr_host_model host_u (.clk(core_clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));

  // ******
  // Shared tasks
  // ******
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Outputs lag the register by a cycle; let them land
  task automatic settle();
    repeat (4) @(negedge core_clk);
  endtask

  task automatic rd_check(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.rd(a, d, v);
    check({7'h00, v, d}, {8'h01, exp});
  endtask

  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    settle();
  endtask

  task automatic pin_update();
    @(negedge core_clk);
    upd_pin = 1'b1;
    @(negedge core_clk);
    upd_pin = 1'b0;
    settle();
  endtask

  // ******
  // Scenarios
  // ******
  task automatic t_reset_values();
    do_reset(1'b0);
    rd_check(ADDR_POWER_DOWN, PD_RESET_NORMAL);
    check({hstl_off, cmos_on, mult_pd, sys_run}, 16'h000d);
    check(fb_ratio, 16'h0004);
    check(cp_ua, CP_UA_250);
    do_reset(1'b1);
    rd_check(ADDR_POWER_DOWN, PD_RESET_STRAP);
    check(mult_pd, 16'h0001);
    strap = 1'b0;
  endtask

  // Each power bit alone, full power-down after the others since it overrides all, then all clear
  task automatic t_power_bits();
    logic [7:0] vals [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h01, 8'h02,
                             8'h00};
    logic [7:0] w;
    logic f;
    foreach (vals[i])
    begin
      w = vals[i];
      f = w[1];
      host_u.wr(ADDR_POWER_DOWN, w);
      settle();
      check({hstl_off, cmos_on, dbl_on, mult_pd, dig_gate, chip_off,
        sys_run}, {w[7] | f, w[6] & !f, w[5] & !f, w[4] | f, w[0] | f,
        f, !f});
    end
    dbl_en = 1'b0;
    host_u.wr(ADDR_POWER_DOWN, 8'h20);
    settle();
    check(dbl_on, 16'h0000);
    pd_pin = 1'b1;
    settle();
    check({chip_off, sys_run, hstl_off}, 16'h0005);
    pd_pin = 1'b0;
    dbl_en = 1'b1;
  endtask

  // Buffered divider: pending versus active readback, both update paths
  task automatic t_mirror();
    host_u.wr(ADDR_FB_DIVIDER, 8'h05);
    settle();
    check(fb_ratio, 16'h0004);
    rd_check(ADDR_FB_DIVIDER, 8'h00);
    host_u.wr(ADDR_READBACK_SRC, 8'h01);
    rd_check(ADDR_FB_DIVIDER, 8'h05);
    host_u.wr(ADDR_SW_UPDATE, 8'h01);
    settle();
    check(fb_ratio, 16'h000e);
    rd_check(ADDR_SW_UPDATE, 8'h00);
    host_u.wr(ADDR_FB_DIVIDER, 8'hff);
    pin_update();
    check(fb_ratio, 16'h0042);
    host_u.wr(ADDR_READBACK_SRC, 8'h00);
    rd_check(ADDR_FB_DIVIDER, 8'h1f);
  endtask

  // Charge pump codes, doubler and range; ratio is 66 until the last check clears the field for ratio 4
  task automatic t_pll();
    logic [8:0] ua [4] = '{CP_UA_250, CP_UA_375, CP_UA_OFF, CP_UA_125};
    for (int c = 0; c < 4; c++)
    begin
      host_u.wr(ADDR_PLL_PARAMS, 8'h0c | 8'(c));
      pin_update();
      check({cp_off, cp_ua}, {c == 2, ua[c]});
      check({ref_dbl, osc_rng}, 16'h0003);
    end
    host_u.wr(ADDR_PLL_PARAMS, 8'h80);
    pin_update();
    check({ref_dbl, osc_rng}, 16'h0001);
    host_u.wr(ADDR_FB_DIVIDER, 8'h00);
    host_u.wr(ADDR_PLL_PARAMS, 8'h84);
    pin_update();
    check(osc_rng, 16'h0000);
  endtask

  task automatic t_resets();
    int p;
    int t;
    p = pulses;
    host_u.wr(ADDR_CORE_RESET, 8'h01);
    settle();
    check(16'(pulses - p), 16'h0001);
    rd_check(ADDR_CORE_RESET, 8'h00);
    // Integer reset left clear, so only the prescaler reset stops ticks
    host_u.wr(ADDR_DIV_RESET, 8'hf9);
    settle();
    check(fund_off, 16'h0001);
    t = ticks;
    repeat (8) @(negedge core_clk);
    check(16'(ticks - t), 16'h0000);
    rd_check(ADDR_DIV_RESET, DIV_RESET_MASK & 8'hf9);
    host_u.wr(ADDR_DIV_RESET, 8'h02);
    settle();
    t = ticks;
    repeat (8) @(negedge core_clk);
    check(16'(ticks - t), 16'h0000);
    host_u.wr(ADDR_DIV_RESET, 8'h00);
    settle();
    t = ticks;
    repeat (8) @(negedge core_clk);
    check(16'(ticks - t), 16'h0004);
  endtask

  task automatic t_reserved();
    logic [12:0] a [3] = '{ADDR_RSVD_POWER, ADDR_RSVD_DIVIDER, 13'h0100};
    foreach (a[i])
    begin
      host_u.wr(a[i], 8'hff);
      rd_check(a[i], 8'h00);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    t_reset_values();
    t_power_bits();
    t_mirror();
    t_pll();
    t_resets();
    t_reserved();
    end_sim();
  end
endmodule
